// ### rtl/flc_class_selector.v
`timescale 1ns/1ps
// Overview of operation
// R1: Average correlation is mean of half-frame, look-ahead
// R2: Tilt equals 10*log10 of floored product
// R3: Pitch count sums two adjacent lag differences
// R4: Zero crossings over samples 112 to 368
// R5: Scale linearly, clip; energy clips from half
// R6: Correlation and tilt slopes and offsets
// R7: Pitch count slope and offset
// R8: Energy and zero-crossing slopes and offsets
// R9: Merit is weighted sum divided by six
// R10: After voiced classes pick voiced, transition, unvoiced
// R11: After unvoiced classes pick onset, transition, unvoiced
// R12: Inactive, unvoiced mode or low energy forces unvoiced
// R13: Unvoiced transition only after unvoiced classes
// R14: Voiced classes only after voiced or onset
// R15: Onset marks stable voicing after unvoiced
// R16: Inactive and audio classes never produced
// R17: Upstream supplies current raw coding mode
// R18: Class register is previous class, resets unvoiced
// R19: Three-bit class with one-cycle valid strobe

`include "flc_defs.vh"

module flc_class_selector (
  input  wire               clk_in,
  input  wire               arst_n_in,
  input  wire               frame_start_in,
  input  wire               sample_valid_in,
  input  wire signed [15:0] sample_in,
  input  wire               params_valid_in,
  input  wire signed [15:0] corr_half_in,
  input  wire signed [15:0] corr_look_in,
  input  wire        [15:0] tilt0_in,
  input  wire        [15:0] tilt1_in,
  input  wire        [9:0]  pitch0_in,
  input  wire        [9:0]  pitch1_in,
  input  wire        [9:0]  pitch2_in,
  input  wire signed [15:0] rel_energy_in,
  input  wire               activity_flag_in,
  input  wire               unvoiced_coding_mode_in,
  output reg                busy_out,
  output reg                class_valid_out,
  output reg         [2:0]  concealment_class_out,
  output reg         [12:0] merit_score_out,
  output reg  signed [9:0]  zero_cross_count_out
);

  // ---------------------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_LOG  = 2'h1;
  localparam [1:0] ST_SUM  = 2'h2;

  reg        [1:0]  state_q;
  reg        [8:0]  idx_q;
  reg signed [15:0] prev_smp_q;
  reg signed [9:0]  zc_acc_q;
  reg signed [16:0] avg_corr_q;
  reg        [31:0] prod_q;
  reg        [11:0] pc_q;
  reg signed [15:0] er_q;
  reg signed [9:0]  zc_q;
  reg               force_uv_q;
  reg        [17:0] tilt_db_q;
  reg        [12:0] corr_s_q;
  reg        [12:0] pc_s_q;
  reg        [12:0] er_s_q;
  reg        [12:0] zc_s_q;
  reg        [2:0]  prev_cls_q;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Clip a Q12 value between a lower bound and 1.0
  function [12:0] clip_q12;
    input signed [31:0] x;
    input signed [31:0] lo;
    begin
      if (x < lo) begin
        clip_q12 = lo[12:0];
      end else if (x > `FLC_ONE) begin
        clip_q12 = 13'h1000;
      end else begin
        clip_q12 = x[12:0];
      end
    end
  endfunction

  // log2(1 + i/16) in Q12, interpolated between entries
  function [12:0] log_lut;
    input [4:0] i;
    begin
      case (i)
        5'h00:   log_lut = 13'h0000;
        5'h01:   log_lut = 13'h0166;
        5'h02:   log_lut = 13'h02B8;
        5'h03:   log_lut = 13'h03F8;
        5'h04:   log_lut = 13'h0527;
        5'h05:   log_lut = 13'h0647;
        5'h06:   log_lut = 13'h075A;
        5'h07:   log_lut = 13'h0861;
        5'h08:   log_lut = 13'h095C;
        5'h09:   log_lut = 13'h0A4D;
        5'h0A:   log_lut = 13'h0B35;
        5'h0B:   log_lut = 13'h0C14;
        5'h0C:   log_lut = 13'h0CEB;
        5'h0D:   log_lut = 13'h0DBA;
        5'h0E:   log_lut = 13'h0E83;
        5'h0F:   log_lut = 13'h0F44;
        default: log_lut = 13'h1000;
      endcase
    end
  endfunction

  // Absolute difference of two pitch lags
  function [10:0] abs_diff;
    input [9:0] a;
    input [9:0] b;
    begin
      if (a > b) begin
        abs_diff = {1'b0, a - b};
      end else begin
        abs_diff = {1'b0, b - a};
      end
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Zero-crossing accumulation over the sample stream
  // ---------------------------------------------------------------------------
  // A product is positive only when both samples are non-zero and agree in sign
  wire sign_pos = (sample_in != 16'sh0000) && (prev_smp_q != 16'sh0000) &&
                  (sample_in[15] == prev_smp_q[15]);
  wire in_window = (idx_q >= `FLC_ZC_FIRST) && (idx_q <= `FLC_ZC_LAST);

  // Accumulator holds minus the sign sum, so it is twice the count less the 257-sample window length
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      idx_q      <= 9'h000;
      prev_smp_q <= 16'sh0000;
      zc_acc_q   <= 10'sh000;
    end else if (frame_start_in) begin
      idx_q      <= 9'h000;
      prev_smp_q <= 16'sh0000;
      zc_acc_q   <= 10'sh000;
    end else if (sample_valid_in) begin
      prev_smp_q <= sample_in;
      // Index saturates so a long frame cannot wrap back into the window
      if (idx_q != `FLC_IDX_MAX) begin
        idx_q <= idx_q + 9'h001;
      end
      if (in_window) begin
        if (sign_pos) begin
          zc_acc_q <= zc_acc_q - 10'sh001; // R4
        end else begin
          zc_acc_q <= zc_acc_q + 10'sh001; // R4
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Log2 of the tilt product, floored at 1.0
  // ---------------------------------------------------------------------------
  reg        [4:0]  msb;
  reg        [31:0] norm;
  reg        [4:0]  lut_i;
  reg        [12:0] lut_lo;
  reg        [12:0] lut_step;
  reg        [20:0] interp;
  reg        [16:0] log2_q12;
  reg        [4:0]  int_part;
  integer           b;

  always @* begin
    msb = 5'h00;
    for (b = 0; b < 32; b = b + 1) begin
      if (prod_q[b]) begin
        msb = b[4:0];
      end
    end
    norm     = prod_q << (5'd31 - msb);
    lut_i    = {1'b0, norm[30:27]};
    lut_lo   = log_lut(lut_i);
    lut_step = log_lut(lut_i + 5'h01) - lut_lo;
    interp   = lut_step * norm[26:19];
    int_part = msb - 5'd16;
    if (prod_q < `FLC_PROD_ONE) begin
      log2_q12 = 17'h00000; // R2
    end else begin
      log2_q12 = {int_part[3:0], 13'h0000} >> 1;
      log2_q12 = log2_q12 + {4'h0, lut_lo} + {4'h0, interp[20:8]};
    end
  end

  // ---------------------------------------------------------------------------
  // Linear scaling of the four parameters ready at acceptance
  // ---------------------------------------------------------------------------
  wire signed [31:0] corr_lin = ((avg_corr_q * `FLC_K_CORR) >>> 14) + `FLC_C_CORR; // R6
  wire signed [31:0] pc_lin   = ($signed({20'h00000, pc_q}) * `FLC_K_PC) + `FLC_C_PC; // R7
  wire signed [31:0] er_lin   = ((er_q * `FLC_K_ER) >>> 8) + `FLC_C_ER; // R8
  wire signed [31:0] zc_lin   = ((zc_q * `FLC_K_ZC) >>> 2) + `FLC_C_ZC; // R8
  wire signed [31:0] tilt_dbw = $signed({14'h0000, tilt_db_q});
  wire signed [31:0] tilt_lin = ((tilt_dbw * `FLC_K_TILT) >>> 12) + `FLC_C_TILT; // R6
  wire        [31:0] db_full  = {15'h0000, log2_q12} * `FLC_DB_PER_OCT;

  // ---------------------------------------------------------------------------
  // Merit sum and class decision
  // ---------------------------------------------------------------------------
  wire [12:0] tilt_s = clip_q12(tilt_lin, `FLC_ZERO); // R5
  // Twice the correlation term plus the rest, i.e. six times the merit
  wire [14:0] merit_sum = {1'b0, corr_s_q, 1'b0} + {2'h0, tilt_s} + {2'h0, pc_s_q} +
                          {2'h0, er_s_q} + {2'h0, zc_s_q}; // R9
  wire [29:0] merit_full = merit_sum * `FLC_SIXTH;
  wire prev_unv = (prev_cls_q == `FLC_CLS_UNVOICED) || (prev_cls_q == `FLC_CLS_UNV_TRANS);

  reg [2:0] next_cls;

  // Thresholds compare on the sum so no divider sits in the decision path
  always @* begin
    if (force_uv_q) begin
      next_cls = `FLC_CLS_UNVOICED; // R12
    end else if (prev_unv) begin
      if (merit_sum >= `FLC_TH_ONSET) begin
        next_cls = `FLC_CLS_ONSET; // R11 R15
      end else if (merit_sum >= `FLC_TH_UTRANS) begin
        next_cls = `FLC_CLS_UNV_TRANS; // R11 R13
      end else begin
        next_cls = `FLC_CLS_UNVOICED; // R11
      end
    end else begin
      if (merit_sum >= `FLC_TH_VOICED) begin
        next_cls = `FLC_CLS_VOICED; // R10 R14
      end else if (merit_sum >= `FLC_TH_VTRANS) begin
        next_cls = `FLC_CLS_VOICED_TRANS; // R10 R14
      end else begin
        next_cls = `FLC_CLS_UNVOICED; // R10
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------------------
  // Three-cycle pipeline; a new frame is refused while busy_out is high
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q               <= ST_IDLE;
      busy_out              <= 1'b0;
      class_valid_out       <= 1'b0;
      concealment_class_out <= `FLC_CLS_RESET;
      prev_cls_q            <= `FLC_CLS_RESET;
      merit_score_out       <= 13'h0000;
      zero_cross_count_out  <= 10'sh000;
      avg_corr_q            <= 17'sh00000;
      prod_q                <= 32'h00000000;
      pc_q                  <= 12'h000;
      er_q                  <= 16'sh0000;
      zc_q                  <= 10'sh000;
      force_uv_q            <= 1'b0;
      tilt_db_q             <= 18'h00000;
      corr_s_q              <= 13'h0000;
      pc_s_q                <= 13'h0000;
      er_s_q                <= 13'h0000;
      zc_s_q                <= 13'h0000;
    end else begin
      class_valid_out <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (params_valid_in) begin
            avg_corr_q <= ($signed({corr_half_in[15], corr_half_in}) +
                           $signed({corr_look_in[15], corr_look_in})) >>> 1; // R1
            prod_q     <= tilt0_in * tilt1_in; // R2
            pc_q       <= {1'b0, abs_diff(pitch1_in, pitch0_in)} +
                          {1'b0, abs_diff(pitch2_in, pitch1_in)}; // R3
            er_q       <= rel_energy_in;
            zc_q       <= zc_acc_q; // R4
            // Raw mode flag is taken as already final for this frame
            force_uv_q <= !activity_flag_in || unvoiced_coding_mode_in ||
                          (rel_energy_in < `FLC_ER_FORCE); // R12 R16 R17
            busy_out   <= 1'b1;
            state_q    <= ST_LOG;
          end
        end
        ST_LOG: begin
          tilt_db_q <= db_full[29:12]; // R2
          corr_s_q  <= clip_q12(corr_lin, `FLC_ZERO); // R5
          pc_s_q    <= clip_q12(pc_lin, `FLC_ZERO); // R5
          er_s_q    <= clip_q12(er_lin, `FLC_HALF); // R5
          zc_s_q    <= clip_q12(zc_lin, `FLC_ZERO); // R5
          state_q   <= ST_SUM;
        end
        ST_SUM: begin
          // Only classes 0..4 can leave here; inactive and audio stay decoder-only
          concealment_class_out <= next_cls; // R16 R19
          prev_cls_q            <= next_cls; // R18
          class_valid_out       <= 1'b1; // R19
          merit_score_out       <= merit_full[24:12];
          zero_cross_count_out  <= zc_q;
          busy_out              <= 1'b0;
          state_q               <= ST_IDLE;
        end
        default: begin
          busy_out <= 1'b0;
          state_q  <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // flc_class_selector

// ### rtl/flc_defs.vh
`ifndef FLC_DEFS_VH
`define FLC_DEFS_VH

// ---------------------------------------------------------------------------
// Concealment class encoding (3 bits)
// ---------------------------------------------------------------------------
`define FLC_CLS_UNVOICED      3'h0
`define FLC_CLS_UNV_TRANS     3'h1
`define FLC_CLS_VOICED_TRANS  3'h2
`define FLC_CLS_VOICED        3'h3
`define FLC_CLS_ONSET         3'h4
`define FLC_CLS_INACTIVE      3'h5
`define FLC_CLS_AUDIO         3'h6
`define FLC_CLS_RESET         3'h0

// ---------------------------------------------------------------------------
// Zero-crossing window, pre-processed sample indices 112..368
// ---------------------------------------------------------------------------
`define FLC_ZC_FIRST          9'h070
`define FLC_ZC_LAST           9'h170
`define FLC_IDX_MAX           9'h1FF

// ---------------------------------------------------------------------------
// Scaling pairs, all in Q12 (4096 = 1.0)
// ---------------------------------------------------------------------------
`define FLC_K_CORR            32'sh00002DB6
`define FLC_C_CORR           -32'sh00001493
`define FLC_K_TILT            32'sh000000AB
`define FLC_C_TILT            32'sh00000000
`define FLC_K_PC             -32'sh00000125
`define FLC_C_PC              32'sh00001DB6
`define FLC_K_ER              32'sh000000CD
`define FLC_C_ER              32'sh00000733
`define FLC_K_ZC             -32'sh000000A4
`define FLC_C_ZC              32'sh00002666
`define FLC_ZERO              32'sh00000000
`define FLC_HALF              32'sh00000800
`define FLC_ONE               32'sh00001000

// Ten times log10(2) in Q12: turns a log2 into the 10*log10 tilt in dB
`define FLC_DB_PER_OCT        32'sh0000302A
// Tilt product of 1.0 in Q16.16; anything below is floored to it
`define FLC_PROD_ONE          32'h00010000

// ---------------------------------------------------------------------------
// Merit thresholds expressed on the weighted sum (six times the merit, Q12)
// ---------------------------------------------------------------------------
`define FLC_TH_VOICED         15'h3F5D
`define FLC_TH_VTRANS         15'h2F0B
`define FLC_TH_ONSET          15'h3C7B
`define FLC_TH_UTRANS         15'h3829
// Reciprocal of six in Q12, only for the merit score output
`define FLC_SIXTH             15'h02AB

// Relative energy floor, -6 dB in Q8.8
`define FLC_ER_FORCE         -16'sh0600

`endif

// ### sim/flc_class_selector_bench.sv
`timescale 1ns/1ps
`include "flc_defs.vh"
module flc_class_selector_bench;
  reg                clk_in, arst_n_in, go, pat, params_valid_in, act, uvm;
  reg         [15:0] ch, cl, er, t0, t1;
  reg         [9:0]  p1;
  wire               fs, sv, done, busy, cv;
  wire signed [15:0] smp;
  wire        [2:0]  cls;
  wire        [12:0] merit;
  wire signed [9:0]  zc;
  integer            n_mismatch, compares;

  flc_up_model up (.clk_in(clk_in), .go_in(go), .pat_in(pat), .frame_start_out(fs),
    .sample_valid_out(sv), .sample_out(smp), .done_out(done));
  flc_class_selector dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .frame_start_in(fs),
    .sample_valid_in(sv), .sample_in(smp), .params_valid_in(params_valid_in),
    .corr_half_in(ch), .corr_look_in(cl), .tilt0_in(t0), .tilt1_in(t1),
    .pitch0_in(10'h064), .pitch1_in(p1), .pitch2_in(10'h064), .rel_energy_in(er),
    .activity_flag_in(act), .unvoiced_coding_mode_in(uvm), .busy_out(busy),
    .class_valid_out(cv), .concealment_class_out(cls), .merit_score_out(merit),
    .zero_cross_count_out(zc));

  // ----------------------------------------------
  // Shared tasks
  // ----------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  task check(input [63:0] what, input [15:0] seen, input [15:0] want);
    begin
      compares = compares + 1;
      if (seen !== want) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED %0s expected %h seen %h", what, want, seen);
      end
    end
  endtask
  task close_out;
    begin
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task do_reset;
    begin
      arst_n_in = 1'b0;
      repeat (10) @(posedge clk_in);
      #1 arst_n_in = 1'b1;
      check("rst_cls", cls, `FLC_CLS_RESET);
      check("rst_flag", {busy, cv}, 0);
    end
  endtask
  // Params are held three cycles: the taking edge plus the two busy edges.
  // A fourth edge would meet an idle block and start a second frame.
  task frame(input [15:0] c_h, c_l, ta, tb, input [9:0] pm, input [15:0] e,
             input a, u, zp, input [2:0] want);
    integer i;
    reg     seen;
    begin
      pat = zp;
      go = 1'b1;
      @(posedge clk_in);
      #1 go = 1'b0;
      i = 0;
      do begin
        @(posedge clk_in);
        i = i + 1;
      end while (!done && i < 500);
      check("samples", done, 1);
      // A stalled upstream model ends the run here rather than hanging
      if (!done) close_out;
      #1 {ch, cl, t0, t1, p1, er, act, uvm} = {c_h, c_l, ta, tb, pm, e, a, u};
      params_valid_in = 1'b1;
      seen = 1'b0;
      for (i = 0; i < 3; i = i + 1) begin
        @(posedge clk_in);
        #1 seen = seen | cv;
      end
      params_valid_in = 1'b0;
      check("strobe", seen, 1);
      check("class", cls, want);
      check("zc", zc, zp ? 10'sd257 : -10'sd257);
      repeat (2) begin
        @(posedge clk_in);
        #1 check("extra", cv, 0);
      end
    end
  endtask
  task hi(input a, u, input [15:0] e, input [2:0] want);
    frame(16'h4000, 16'h4000, 16'h1000, 16'h1000, 10'h064, e, a, u, 0, want);
  endtask
  task mid(input [15:0] c_l, ta, input [9:0] pm, input zp, input [2:0] want);
    frame(16'h4000, c_l, ta, 16'h0100, pm, 16'h0000, 1, 0, zp, want);
  endtask

  // ----------------------------------------------
  // Scenarios
  // ----------------------------------------------
  task t_onset_voiced;
    begin
      hi(1, 0, 16'h0C00, `FLC_CLS_ONSET);
      check("merit", merit > 13'd4080 && merit < 13'd4112, 1);
      hi(1, 0, 16'h0C00, `FLC_CLS_VOICED);
    end
  endtask
  task t_voiced_branch;
    begin
      mid(16'h4000, 16'h0100, 10'h064, 1, `FLC_CLS_VOICED_TRANS);
      mid(16'h0000, 16'h0100, 10'h064, 0, `FLC_CLS_UNVOICED);
    end
  endtask
  task t_unvoiced_branch;
    begin
      mid(16'h4000, 16'h0100, 10'h064, 1, `FLC_CLS_UNVOICED);
      mid(16'h4000, 16'h0200, 10'h064, 1, `FLC_CLS_UNV_TRANS);
      mid(16'h4000, 16'h0200, 10'h064, 1, `FLC_CLS_UNV_TRANS);
    end
  endtask
  task t_force;
    begin
      hi(0, 0, 16'h0C00, `FLC_CLS_UNVOICED);
      hi(1, 1, 16'h0C00, `FLC_CLS_UNVOICED);
      hi(1, 0, 16'hF980, `FLC_CLS_UNVOICED);
      hi(1, 0, 16'hFA00, `FLC_CLS_ONSET);
    end
  endtask
  task t_reset_mid;
    begin
      hi(1, 0, 16'h0C00, `FLC_CLS_VOICED);
      do_reset;
      mid(16'h4000, 16'h0100, 10'h064, 1, `FLC_CLS_UNVOICED);
    end
  endtask
  task t_pitch;
    begin
      hi(1, 0, 16'h0C00, `FLC_CLS_ONSET);
      mid(16'h4000, 16'h0100, 10'h06F, 1, `FLC_CLS_UNVOICED);
    end
  endtask

  initial begin
    {arst_n_in, go, pat, params_valid_in, act, uvm} = 6'h00;
    {ch, cl, er, t0, t1, p1} = 90'h0;
    n_mismatch = 0;
    compares = 0;
    do_reset;
    t_onset_voiced;
    t_voiced_branch;
    t_unvoiced_branch;
    t_force;
    t_reset_mid;
    t_pitch;
    close_out;
  end
endmodule // flc_class_selector_bench

// ### sim/flc_class_selector_chk.sv
`timescale 1ns/1ps
// ----------------------------------------------
// Strobe timing and class order at the ports
// ----------------------------------------------
module flc_class_selector_chk (
  input wire               clk_in,
  input wire               arst_n_in,
  input wire               params_valid_in,
  input wire               activity_flag_in,
  input wire               unvoiced_coding_mode_in,
  input wire signed [15:0] rel_energy_in,
  input wire               busy_out,
  input wire               class_valid_out,
  input wire        [2:0]  concealment_class_out
);
  // A request right after a taken one is ignored, so it is not a cause
  wire       take = params_valid_in && !busy_out;
  wire [2:0] cls  = concealment_class_out;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  resp_time_a: assert property (take && !$past(take) |-> ##3 class_valid_out)
    else $error("class strobe not three cycles after request");
  stray_strobe_a: assert property (class_valid_out |-> $past(take, 3))
    else $error("class strobe without request");
  busy_width_a: assert property ($rose(busy_out) |-> busy_out [*2] ##1 !busy_out)
    else $error("busy not two cycles wide");
  valid_pulse_a: assert property (class_valid_out |=> !class_valid_out)
    else $error("class strobe longer than one cycle");
  no_dec_class_a: assert property (class_valid_out |-> cls < 3'h5)
    else $error("decoder-only class produced");
  class_hold_a: assert property (!class_valid_out |-> $stable(cls))
    else $error("class changed without strobe");
  ut_order_a: assert property (class_valid_out && cls == 3'h1 |-> $past(cls) <= 3'h1)
    else $error("unvoiced transition after voiced class");
  voiced_order_a: assert property (class_valid_out && (cls == 3'h2 || cls == 3'h3)
    |-> $past(cls) >= 3'h2)
    else $error("voiced class after unvoiced class");
  onset_order_a: assert property (class_valid_out && cls == 3'h4 |-> $past(cls) <= 3'h1)
    else $error("onset after voiced class");
  force_uv_a: assert property (take && !$past(take) && (!activity_flag_in ||
    unvoiced_coding_mode_in || rel_energy_in < -16'sh0600) |-> ##3 cls == 3'h0)
    else $error("forced unvoiced not applied");
endmodule // flc_class_selector_chk

bind flc_class_selector flc_class_selector_chk chk (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .params_valid_in(params_valid_in),
  .activity_flag_in(activity_flag_in), .unvoiced_coding_mode_in(unvoiced_coding_mode_in),
  .rel_energy_in(rel_energy_in), .busy_out(busy_out), .class_valid_out(class_valid_out),
  .concealment_class_out(concealment_class_out));

// ### sim/flc_up_model.sv
`timescale 1ns/1ps
// ----------------------------------------------
// Upstream model: frame start, then samples
// ----------------------------------------------
module flc_up_model (
  input  wire              clk_in,
  input  wire              go_in,
  input  wire              pat_in,
  output reg               frame_start_out,
  output reg               sample_valid_out,
  output reg signed [15:0] sample_out,
  output reg               done_out
);
  integer n;
  // Pattern 1 alternates over samples 111..368, starting one sample ahead of the counted span, so an off-by-one
  // window edge changes the count
  initial begin
    {frame_start_out, sample_valid_out, done_out} = 3'h1;
    sample_out = 16'h0000;
    forever begin
      @(posedge clk_in);
      if (go_in) begin
        #1 done_out = 1'b0;
        frame_start_out = 1'b1;
        @(posedge clk_in);
        #1 frame_start_out = 1'b0;
        for (n = 0; n < 380; n = n + 1) begin
          sample_valid_out = 1'b1;
          sample_out = (pat_in && n > 110 && n < 369 && n % 2) ? -16'sh0100 : 16'sh0100;
          @(posedge clk_in);
          #1;
        end
        // Released line shows the inverse, not a held value
        sample_valid_out = 1'b0;
        sample_out = ~sample_out;
        done_out = 1'b1;
      end
    end
  end
endmodule // flc_up_model
